// ===== sft_pkg.sv
package sft_pkg;

  // ----------------------------------------------------------------------
  // Register indices (word addresses); byte address is four times these.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_POWERDOWN_WINDOW     = 8'h9e;
  localparam logic [7:0]  IDX_SUBFRAME_COUNT_CFG   = 8'h9f;
  localparam logic [7:0]  IDX_CAPTURE_POSITION     = 8'ha0;
  localparam logic [7:0]  IDX_NONLIN_COEFF_SET_A   = 8'ha2;
  localparam logic [7:0]  IDX_NONLIN_COEFF_SET_B   = 8'ha3;
  localparam logic [7:0]  IDX_TIMING_CONTROL       = 8'ha1;
  localparam logic [7:0]  IDX_TIMING_STATUS        = 8'ha9;

  // ----------------------------------------------------------------------
  // Field layout and reset values.
  // ----------------------------------------------------------------------
  localparam int          REG_WIDTH                = 24;
  localparam int          HI_FIELD_LSB             = 12;
  localparam int          FIELD12_WIDTH            = 12;
  localparam int          LOW16_WIDTH              = 16;
  localparam int          BYTE_HI_LSB              = 16;
  localparam logic [23:0] RST_POWERDOWN_WINDOW     = 24'h000000;
  localparam logic [23:0] RST_SUBFRAME_COUNT_CFG   = 24'h000000;
  localparam logic [23:0] RST_CAPTURE_POSITION     = 24'h002198;
  localparam logic [23:0] RST_NONLIN_COEFF         = 24'h000000;
  localparam logic [15:0] RST_SUBFRAME_CLOCK_COUNT = 16'h2710;

  // ----------------------------------------------------------------------
  // Timing: the sub-frame clock period and the sub-frame length.
  // ----------------------------------------------------------------------
  localparam int          TICK_PERIOD_NS           = 25;
  localparam int          SYS_CLK_PERIOD_NS        = 10;
  localparam int          SUBFRAME_TIME_US         = 250;

endpackage

// ===== sft_tick_gen.sv
`timescale 1ns/1ps
// Fractional divider that turns the 100 MHz clock into one pulse per
// 25 ns timing-generator period (adds 10 per cycle, wraps at 25).
module sft_tick_gen #(
  parameter int PERIOD_NS = 25,
  parameter int STEP_NS   = 10
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      tick_o
);

  // Phase accumulator in nanoseconds.
  logic [7:0] phase;
  logic [7:0] next_phase;

  // Wrap when a whole period has accumulated; the remainder carries so
  // the long-run rate is exact even though the pulses are uneven.
  always_comb begin
    next_phase = phase + 8'(STEP_NS);
    if (next_phase >= 8'(PERIOD_NS)) begin
      next_phase = next_phase - 8'(PERIOD_NS);
    end
  end

  // Accumulator and pulse register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      phase  <= next_phase;
      tick_o <= (phase + 8'(STEP_NS)) >= 8'(PERIOD_NS);
    end
  end

endmodule

// ===== sft_regs.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
// How it works
// - Power-down asserted only outside start..end window.
// - Averaged sub-frames equal field plus one.
// - Frame holds total field plus one sub-frames.
// - Sub-frame lasts clock count times 25 ns.
// - Capture strobe at programmed count, reset 2198h.
// - Capture register upper byte reserved, reads zero.
// - Cubic coefficient split across two upper bytes.
// - Offset coefficients stored in low sixteen bits.
module sft_regs #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // APB slave.
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_WIDTH-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  // Channel and current selection from the illumination sequencer.
  input  wire logic [1:0]            tx_channel_i,
  input  wire logic                  high_current_i,
  // Timing outputs.
  output logic                       dyn_powerdown_o,
  output logic                       capture_strobe_o,
  output logic                       frame_start_o,
  output logic                       averaging_active_o,
  output logic [11:0]                subframe_index_o,
  // Coefficients for the channel and current level now in use.
  output logic [15:0]                active_cubic_coeff_o,
  output logic [15:0]                active_offset_coeff_o,
  output logic                       coeff_valid_o
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [23:0] powerdown_window;       // End in 23:12, start in 11:0.
  logic [23:0] subframe_count_config;  // Averaged in 23:12, total in 11:0.
  logic [15:0] capture_position_count; // Upper byte is not stored at all.
  logic [23:0] nonlin_coeff_set_a;     // Cubic high byte and ch0 offset.
  logic [23:0] nonlin_coeff_set_b;     // Cubic low byte and ch1 offset.
  logic [15:0] subframe_clock_count;   // Timing-generator periods per sub-frame.
  logic        run_enable;             // Timing generator runs while set.

  // Field views.
  logic [11:0] powerdown_window_end;
  logic [11:0] powerdown_window_start;
  logic [11:0] averaged_subframe_count;
  logic [11:0] total_subframe_count;
  logic [15:0] cubic_coeff_low_ch1;
  logic [15:0] offset_coeff_high_ch0;
  logic [15:0] offset_coeff_low_ch1;

  assign powerdown_window_end    = powerdown_window[23:12];
  assign powerdown_window_start  = powerdown_window[11:0];
  assign averaged_subframe_count = subframe_count_config[23:12];
  assign total_subframe_count    = subframe_count_config[11:0];
  assign cubic_coeff_low_ch1     = {nonlin_coeff_set_a[23:16], nonlin_coeff_set_b[23:16]};
  assign offset_coeff_high_ch0   = nonlin_coeff_set_a[15:0];
  assign offset_coeff_low_ch1    = nonlin_coeff_set_b[15:0];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic [ADDR_WIDTH-3:0] word_idx;    // Word index from the byte address.
  logic                  access;      // Access phase; always one wait-free cycle.
  logic                  wr_en;
  logic                  hit;         // Address names a register.
  logic [31:0]           next_rdata;

  assign word_idx = paddr_i[ADDR_WIDTH-1:2];
  assign access   = psel_i & penable_i;
  assign wr_en    = access & pwrite_i & hit;

  // Read mux; unmapped words read zero and answer with an error.
  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h00000000;
    case (word_idx)
      (ADDR_WIDTH-2)'(sft_pkg::IDX_POWERDOWN_WINDOW):   next_rdata = {8'h00, powerdown_window};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_SUBFRAME_COUNT_CFG): next_rdata = {8'h00, subframe_count_config};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_CAPTURE_POSITION):   next_rdata = {16'h0000, capture_position_count};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_NONLIN_COEFF_SET_A): next_rdata = {8'h00, nonlin_coeff_set_a};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_NONLIN_COEFF_SET_B): next_rdata = {8'h00, nonlin_coeff_set_b};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_TIMING_CONTROL):     next_rdata = {15'h0000, run_enable, subframe_clock_count};
      (ADDR_WIDTH-2)'(sft_pkg::IDX_TIMING_STATUS):      next_rdata = {18'h00000, averaging_active_o, frame_start_o,
                                                                      subframe_index_o};
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Bus answer: pready is registered from the setup cycle, so it stands
  // high for exactly the one access cycle and no wait state is inserted.
  // Read data and the error flag are registered at the same edge.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      // Answer one cycle after setup: pready high for exactly the access.
      pready_o  <= psel_i & ~penable_i;
      prdata_o  <= next_rdata;
      pslverr_o <= psel_i & ~penable_i & ~hit;
    end
  end

  logic wr_take;
  assign wr_take = wr_en & pready_o;

  // Byte-lane merge helper for 24-bit registers.
  function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] d, input logic [3:0] s);
    merge24 = old;
    for (int b = 0; b < 3; b++) begin
      if (s[b]) begin
        merge24[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  // Capture word merged with its reserved byte forced empty; only 15:0 is kept.
  logic [23:0] capture_merged;
  assign capture_merged = merge24({8'h00, capture_position_count}, pwdata_i, pstrb_i);

  // Register writes take effect at the edge where pready is sampled high.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      powerdown_window       <= sft_pkg::RST_POWERDOWN_WINDOW;
      subframe_count_config  <= sft_pkg::RST_SUBFRAME_COUNT_CFG;
      capture_position_count <= sft_pkg::RST_CAPTURE_POSITION[15:0];
      nonlin_coeff_set_a     <= sft_pkg::RST_NONLIN_COEFF;
      nonlin_coeff_set_b     <= sft_pkg::RST_NONLIN_COEFF;
      subframe_clock_count   <= sft_pkg::RST_SUBFRAME_CLOCK_COUNT;
      run_enable             <= 1'b0;
    end else if (wr_take) begin
      case (word_idx)
        (ADDR_WIDTH-2)'(sft_pkg::IDX_POWERDOWN_WINDOW):
          powerdown_window <= merge24(powerdown_window, pwdata_i, pstrb_i);
        (ADDR_WIDTH-2)'(sft_pkg::IDX_SUBFRAME_COUNT_CFG):
          subframe_count_config <= merge24(subframe_count_config, pwdata_i, pstrb_i);
        (ADDR_WIDTH-2)'(sft_pkg::IDX_CAPTURE_POSITION): begin
          capture_position_count <= capture_merged[15:0];
        end
        (ADDR_WIDTH-2)'(sft_pkg::IDX_NONLIN_COEFF_SET_A):
          nonlin_coeff_set_a <= merge24(nonlin_coeff_set_a, pwdata_i, pstrb_i);
        (ADDR_WIDTH-2)'(sft_pkg::IDX_NONLIN_COEFF_SET_B):
          nonlin_coeff_set_b <= merge24(nonlin_coeff_set_b, pwdata_i, pstrb_i);
        (ADDR_WIDTH-2)'(sft_pkg::IDX_TIMING_CONTROL): begin
          if (pstrb_i[0]) begin
            subframe_clock_count[7:0] <= pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            subframe_clock_count[15:8] <= pwdata_i[15:8];
          end
          if (pstrb_i[2]) begin
            run_enable <= pwdata_i[16];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sub-frame timing
  // ----------------------------------------------------------------------
  logic        gen_tick;   // One pulse per 25 ns timing-generator clock.
  logic [15:0] gen_count;  // Timing-generator clocks within the sub-frame.
  logic        sub_end;

  sft_tick_gen #(
    .PERIOD_NS (sft_pkg::TICK_PERIOD_NS),
    .STEP_NS   (sft_pkg::SYS_CLK_PERIOD_NS)
  ) u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_o  (gen_tick)
  );

  // A count of zero is treated as one so the sub-frame never stalls.
  // sub-frame length
  assign sub_end = gen_tick & (gen_count + 16'h0001 >= subframe_clock_count);

  // Clock counter within a sub-frame.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gen_count <= 16'h0000;
    end else if (!run_enable) begin
      gen_count <= 16'h0000;
    end else if (sub_end) begin
      gen_count <= 16'h0000;
    end else if (gen_tick) begin
      gen_count <= gen_count + 16'h0001;
    end
  end

  // Sub-frame index; wraps after total plus one sub-frames.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      subframe_index_o <= 12'h000;
      frame_start_o    <= 1'b0;
    end else if (!run_enable) begin
      subframe_index_o <= 12'h000;
      frame_start_o    <= 1'b0;
    end else if (sub_end && subframe_index_o >= total_subframe_count) begin
      subframe_index_o <= 12'h000;
      frame_start_o    <= 1'b1;
    end else begin
      frame_start_o <= 1'b0;
      if (sub_end) begin
        subframe_index_o <= subframe_index_o + 12'h001;
      end
    end
  end

  // Window flags, registered straight to the outputs.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dyn_powerdown_o    <= 1'b0;
      averaging_active_o <= 1'b0;
      capture_strobe_o   <= 1'b0;
    end else begin
      dyn_powerdown_o    <= run_enable & ((subframe_index_o < powerdown_window_start) |
                                          (subframe_index_o > powerdown_window_end));
      averaging_active_o <= run_enable & (subframe_index_o <= averaged_subframe_count);
      capture_strobe_o   <= run_enable & gen_tick & (gen_count == capture_position_count);
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient selection
  // ----------------------------------------------------------------------
  // Only two channel/current pairs are held here; others report invalid.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_cubic_coeff_o  <= 16'h0000;
      active_offset_coeff_o <= 16'h0000;
      coeff_valid_o         <= 1'b0;
    end else if (tx_channel_i == 2'd0 && high_current_i) begin
      active_cubic_coeff_o  <= 16'h0000;
      active_offset_coeff_o <= offset_coeff_high_ch0;
      coeff_valid_o         <= 1'b1;
    end else if (tx_channel_i == 2'd1 && !high_current_i) begin
      active_cubic_coeff_o  <= cubic_coeff_low_ch1;
      active_offset_coeff_o <= offset_coeff_low_ch1;
      coeff_valid_o         <= 1'b1;
    end else begin
      active_cubic_coeff_o  <= 16'h0000;
      active_offset_coeff_o <= 16'h0000;
      coeff_valid_o         <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  powerdown_outside_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (run_enable && subframe_index_o >= powerdown_window_start && subframe_index_o <= powerdown_window_end
     && $stable(powerdown_window) && $stable(run_enable)) |=> !dyn_powerdown_o)
    else $error("power-down asserted inside window");

  averaging_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (run_enable && $stable(run_enable) && subframe_index_o == averaged_subframe_count
     && $stable(subframe_count_config)) |=> averaging_active_o)
    else $error("last averaged sub-frame not flagged");

  frame_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
    frame_start_o |-> subframe_index_o == 12'h000)
    else $error("frame start without index restart");

  index_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (run_enable && sub_end && subframe_index_o == total_subframe_count) |=> frame_start_o)
    else $error("frame did not restart after last sub-frame");

  subframe_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (gen_tick && gen_count == 16'h0000 && subframe_clock_count > 16'h0001 && $stable(subframe_clock_count)
     && run_enable) |-> ##[1:3] (gen_tick && gen_count == 16'h0001))
    else $error("sub-frame counter did not advance");

  capture_strobe_a: assert property (@(posedge clk_i) disable iff (reset_i)
    capture_strobe_o |-> $past(gen_tick) && $past(gen_count) == $past(capture_position_count))
    else $error("capture strobe at wrong count");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pready_o && $past(word_idx) == (ADDR_WIDTH-2)'(sft_pkg::IDX_CAPTURE_POSITION)) |-> prdata_o[31:16] == 16'h0000)
    else $error("reserved capture bits not zero");

  cubic_pair_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!$past(reset_i) && $past(tx_channel_i) == 2'd1 && !$past(high_current_i)) |-> active_cubic_coeff_o
      == {$past(nonlin_coeff_set_a[23:16]), $past(nonlin_coeff_set_b[23:16])})
    else $error("cubic coefficient bytes misordered");

  offset_ch0_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!$past(reset_i) && $past(tx_channel_i) == 2'd0 && $past(high_current_i)) |-> coeff_valid_o
      && active_offset_coeff_o == $past(nonlin_coeff_set_a[15:0]))
    else $error("channel 0 offset not selected");

endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------------
  // Stimulus and observation signals.
  // ----------------------------------------------------------------------
  logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, high_current_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, wd;
  logic [3:0]  pstrb_i, st;
  logic [1:0]  tx_channel_i;
  logic        pready_o, pslverr_o, er, dyn_powerdown_o, capture_strobe_o, frame_start_o, averaging_active_o;
  logic [11:0] subframe_index_o, idx, prev_idx;
  logic [15:0] active_cubic_coeff_o, active_offset_coeff_o;
  logic        coeff_valid_o;
  logic [31:0] seed = 32'h9b0d1548;  // Fixed seed keeps every run repeatable.
  logic [23:0] shadow [5];           // Expected contents of the five stored registers.
  logic [7:0]  regs [5] = '{sft_pkg::IDX_POWERDOWN_WINDOW, sft_pkg::IDX_SUBFRAME_COUNT_CFG,
                            sft_pkg::IDX_CAPTURE_POSITION, sft_pkg::IDX_NONLIN_COEFF_SET_A,
                            sft_pkg::IDX_NONLIN_COEFF_SET_B};
  int          n_fail = 0, samples_checked = 0, k, last_chg, n_chg, n_wrap, n_frm, n_cap, cyc;

  sft_regs #(.ADDR_WIDTH(12)) sft_regs_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .tx_channel_i(tx_channel_i),
    .high_current_i(high_current_i), .dyn_powerdown_o(dyn_powerdown_o), .capture_strobe_o(capture_strobe_o),
    .frame_start_o(frame_start_o), .averaging_active_o(averaging_active_o), .subframe_index_o(subframe_index_o),
    .active_cubic_coeff_o(active_cubic_coeff_o), .active_offset_coeff_o(active_offset_coeff_o),
    .coeff_valid_o(coeff_valid_o));

  // ----------------------------------------------------------------------
  // Clock, watchdog and helpers.
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The whole sequence needs about 800 cycles; 6000 leaves ample margin.
  initial begin
    #60000;
    n_fail++;
    summarize();
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Byte lanes 0..2 follow their strobes; lane 3 has no storage behind it.
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] s,
                                        input bit cap);
    logic [23:0] r;
    r = old;
    for (int b = 0; b < 3; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    if (cap) r[23:16] = 8'h00;  // The capture register's upper byte never holds a value.
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= {2'b00, i, 2'b00};
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 16) n_fail++;
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    {reset_i, psel_i, penable_i, pwrite_i, high_current_i} = 5'b10000;
    {paddr_i, pwdata_i, pstrb_i, tx_channel_i} = '0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    shadow = '{sft_pkg::RST_POWERDOWN_WINDOW, sft_pkg::RST_SUBFRAME_COUNT_CFG, sft_pkg::RST_CAPTURE_POSITION,
               sft_pkg::RST_NONLIN_COEFF, sft_pkg::RST_NONLIN_COEFF};
    // Reset values of the stored registers and of the timing control word.
    for (k = 0; k < 5; k++) begin
      apb(1'b0, regs[k], 32'h0, 4'h0, rd, er);
      chk(rd, {8'h00, shadow[k]});
    end
    apb(1'b0, sft_pkg::IDX_TIMING_CONTROL, 32'h0, 4'h0, rd, er);
    chk(rd, {16'h0000, sft_pkg::RST_SUBFRAME_CLOCK_COUNT});
    // An unmapped word is refused, takes no write and reads as zero.
    apb(1'b1, 8'ha5, 32'hffffffff, 4'hf, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'ha5, 32'h0, 4'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    // Random writes with random strobes, each read straight back.
    repeat (40) begin
      k  = int'(rnd() % 5);
      wd = rnd();
      st = 4'(rnd());
      if (k == 2) wd[23:16] = 8'h00;
      apb(1'b1, regs[k], wd, st, rd, er);
      shadow[k] = merge(shadow[k], wd, st, k == 2);
      apb(1'b0, regs[k], 32'h0, 4'h0, rd, er);
      chk(rd, {8'h00, shadow[k]});
    end
    // Channel and current selection drives the coefficient outputs.
    repeat (24) begin
      @(posedge clk_i);
      wd = rnd();
      tx_channel_i   <= wd[1:0];
      high_current_i <= wd[2];
      @(posedge clk_i);
      @(posedge clk_i);
      chk({31'h0, coeff_valid_o}, {31'h0, (wd[2:0] == 3'b100) || (wd[2:0] == 3'b001)});
      if (wd[2:0] == 3'b100) chk({16'h0, active_offset_coeff_o}, {16'h0, shadow[3][15:0]});
      if (wd[2:0] == 3'b001) begin
        chk({16'h0, active_offset_coeff_o}, {16'h0, shadow[4][15:0]});
        chk({16'h0, active_cubic_coeff_o}, {16'h0, shadow[3][23:16], shadow[4][23:16]});
      end
    end
    // Timing: 4 sub-frames per frame, 2 averaged, window 1..1, capture at 2.
    // software settings
    apb(1'b1, sft_pkg::IDX_POWERDOWN_WINDOW, 32'h00001001, 4'h7, rd, er);
    apb(1'b1, sft_pkg::IDX_SUBFRAME_COUNT_CFG, 32'h00001003, 4'h7, rd, er);
    apb(1'b1, sft_pkg::IDX_CAPTURE_POSITION, 32'h00000002, 4'h7, rd, er);
    apb(1'b1, sft_pkg::IDX_TIMING_CONTROL, 32'h00010004, 4'h7, rd, er);
    {last_chg, n_chg, n_wrap, n_frm, n_cap} = '0;
    prev_idx = subframe_index_o;
    for (cyc = 0; cyc < 420; cyc++) begin
      @(posedge clk_i);
      idx = subframe_index_o;
      if (cyc > 20) begin
        // Flags follow the index one cycle later.
        chk({31'h0, dyn_powerdown_o}, {31'h0, prev_idx != 12'd1});
        chk({31'h0, averaging_active_o}, {31'h0, prev_idx <= 12'd1});
        chk({31'h0, idx <= 12'd3}, 32'h1);
        n_frm += int'(frame_start_o);
        n_cap += int'(capture_strobe_o);
        if (idx != prev_idx) begin
          if (n_chg > 0) chk(cyc - last_chg, 10);
          n_chg++;
          n_wrap += int'(idx == 12'd0);
          last_chg = cyc;
        end
      end
      prev_idx = idx;
    end
    // frame restart once per index wrap, capture once per sub-frame
    chk({31'h0, (n_frm - n_wrap) inside {-1, 0, 1}}, 32'h1);
    chk({31'h0, (n_cap - n_chg) inside {-1, 0, 1}}, 32'h1);
    // A second reset in mid-run clears the timing outputs and restores register reset values.
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({subframe_index_o, dyn_powerdown_o, frame_start_o}, 32'h0);
    reset_i <= 1'b0;
    apb(1'b0, sft_pkg::IDX_CAPTURE_POSITION, 32'h0, 4'h0, rd, er);
    chk(rd, {8'h00, sft_pkg::RST_CAPTURE_POSITION});
    // The status word is idle again once reset has stopped the timing generator.
    apb(1'b0, sft_pkg::IDX_TIMING_STATUS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
